// ---- isa_bp_pkg.sv ----
// Shared constants for the backplane block
package isa_bp_pkg;
  // Timer tick divider
  localparam int unsigned OSC_DIV        = 12;
  localparam logic [3:0]  OSC_DIV_LAST   = 4'hB;
  localparam logic [3:0]  OSC_HALF_LAST  = 4'h5;
  // Memory window limits
  localparam logic [31:0] LIMIT_16M      = 32'h0100_0000;
  localparam logic [31:0] LIMIT_1M       = 32'h0010_0000;
  // Coprocessor error interrupt line number
  localparam logic [3:0]  COPROC_IRQ_NUM = 4'hD;
  // Command cycles before ready is checked
  localparam logic [3:0]  CMD_MIN_CYCLES = 4'h4;
  // Backplane reset tail after power-on reset
  localparam logic [3:0]  RESET_HOLD     = 4'hF;

  typedef enum logic [1:0] {
    CYC_CPU,
    CYC_DMA,
    CYC_REFRESH,
    CYC_MASTER
  } cycle_kind_t;
endpackage

// ---- pin_sync.sv ----
// Three-stage pin synchroniser with second/third agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Pin and filtered level
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit changes only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          level_out[g] <= INIT[g];
        end else if (s2_ff[g] == s3_ff[g]) begin
          level_out[g] <= s3_ff[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- osc_divider.sv ----
// Oscillator divider for the interval timer
`timescale 1ns/1ps
`default_nettype none
module osc_divider
  import isa_bp_pkg::*;
(
  // Oscillator and reset
  input  wire logic ref_oscillator_in,
  input  wire logic osc_rst,
  // Divided clock, about 50 percent duty
  output logic      timer_clk_out
);
  logic [3:0] cnt_ff;

  always_ff @(posedge ref_oscillator_in) begin
    if (osc_rst) begin
      cnt_ff <= '0;
    end else if (cnt_ff == OSC_DIV_LAST) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge ref_oscillator_in) begin
    if (osc_rst) begin
      timer_clk_out <= 1'b0;
    end else begin
      timer_clk_out <= (cnt_ff > OSC_HALF_LAST);
    end
  end
endmodule
`default_nettype wire

// ---- isa_backplane_interface.sv ----
// ISA backplane signalling block
//
// Summary of operation
// RULE1: Coprocessor error high requests interrupt thirteen
// RULE2: Drive upper address except in master cycles
// RULE3: Drive high byte enable in own cycles; the code drives it in CPU and DMA cycles only, not in refresh cycles
// RULE4: Master low at DMA grant hands bus over
// RULE5: Sixteen-bit select low sizes transfer sixteen bits
// RULE6: Memory read strobe for reads below 16M
// RULE7: Memory write strobe for writes below 16M
// RULE8: Divide oscillator by twelve for timer
// RULE9: Backplane reset high on power-on reset
// RULE10: Low address bits from host byte enables
// RULE11: Refresh address on latched lines during refresh
// RULE12: Data direction from cycle type and originator
// RULE13: Low memory read strobe below 1M, always driven
// RULE14: Low memory write strobe below 1M, always driven
// RULE15: Terminal count high at DMA count end
// RULE16: Zero wait low ends cycle early
// RULE17: Keyboard reset low requests warm reset
// RULE18: Strap sampled at reset selects CPU mode
// RULE19: Speaker is timer two gated by port bit
// RULE20: Firmware ROM enable during ROM accesses
// RULE21: Backplane clock synchronised with command strobes
// RULE22: Channel ready low inserts wait states
// RULE23: Release command strobes during master cycles
`timescale 1ns/1ps
`default_nettype none
module isa_backplane_interface
  import isa_bp_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        ref_oscillator_in,
  // Local cycle request
  input  wire logic        cyc_start,
  input  wire cycle_kind_t cyc_kind,
  input  wire logic        cyc_write,
  input  wire logic        cyc_io,
  input  wire logic [31:0] host_address,
  input  wire logic [3:0]  host_byte_enables,
  input  wire logic [15:0] refresh_address,
  input  wire logic [15:0] host_write_data,
  input  wire logic        rom_access,
  output logic             cyc_busy,
  output logic             cyc_done,
  output logic [15:0]      host_read_data,
  output logic             cyc_sized_16,
  // DMA and timer status from internal controllers
  input  wire logic        dma_count_end,
  input  wire logic        timer2_out,
  input  wire logic        portb_spk_enable,
  output logic             timer_clk_out,
  output logic             dma_terminal_count,
  output logic             speaker_out,
  // Interrupt and reset requests
  input  wire logic        coproc_error_request,
  output logic             coproc_irq_pending,
  output logic [3:0]       coproc_irq_number,
  input  wire logic        kbd_warm_reset_n,
  output logic             warm_reset_request,
  output logic             backplane_reset_out,
  // Mode strap and peripheral selects
  input  wire logic        clock_select_cpu_strap_in,
  input  wire logic        rtc_select,
  output logic             clock_select_cpu_strap_out,
  output logic             clock_select_cpu_strap_oe,
  output logic             cpu_mode_386,
  output logic             fw_rom_output_enable,
  // Backplane clock
  output logic             backplane_clk,
  // Bus-master indication
  input  wire logic        bus_master_n,
  output logic             master_active,
  // Slave responses
  input  wire logic        mem_sixteen_select_n,
  input  wire logic        zero_wait_request_n,
  input  wire logic        channel_ready,
  // Upper address bits 23..17
  input  wire logic [6:0]  upper_unlatched_address_in,
  output logic [6:0]       upper_unlatched_address_out,
  output logic             upper_unlatched_address_oe,
  // Latched address bits 19..0
  input  wire logic [19:0] latched_system_address_in,
  output logic [19:0]      latched_system_address_out,
  output logic             latched_system_address_oe,
  // High byte enable
  input  wire logic        latched_high_byte_enable_in,
  output logic             latched_high_byte_enable_out,
  output logic             latched_high_byte_enable_oe,
  // Data bus
  input  wire logic [15:0] system_data_bus_in,
  output logic [15:0]      system_data_bus_out,
  output logic             system_data_bus_oe,
  // Memory strobes
  input  wire logic        bp_mem_read_n_in,
  output logic             bp_mem_read_n_out,
  output logic             bp_mem_read_n_oe,
  input  wire logic        bp_mem_write_n_in,
  output logic             bp_mem_write_n_out,
  output logic             bp_mem_write_n_oe,
  output logic             low_mem_read_n,
  output logic             low_mem_write_n
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WAIT,
    ST_END
  } bp_state_t;

  // Window decode shared by all strobes
  function automatic logic below(input logic [31:0] addr, input logic [31:0] lim);
    below = (addr < lim);
  endfunction

  // Lowest two address bits from the byte enables
  function automatic logic [1:0] low_addr_bits(input logic [3:0] be);
    if (be[0]) begin
      low_addr_bits = 2'h0;
    end else if (be[1]) begin
      low_addr_bits = 2'h1;
    end else if (be[2]) begin
      low_addr_bits = 2'h2;
    end else begin
      low_addr_bits = 2'h3;
    end
  endfunction

  bp_state_t   state_ff;
  cycle_kind_t kind_ff;
  logic        write_ff;
  logic        io_ff;
  logic [31:0] addr_ff;
  logic [3:0]  be_ff;
  logic [3:0]  cmd_cnt_ff;
  logic        sized_ff;
  logic        bclk_ff;
  logic [3:0]  rst_cnt_ff;
  logic        strap_taken_ff;

  // Synchronised pin levels
  logic [5:0]  pins_raw;
  logic [5:0]  pins_sync;
  logic        master_sync;
  logic        cs16_sync_n;
  logic        zws_sync_n;
  logic        rdy_sync;
  logic        kbd_sync_n;
  logic        cop_sync;

  assign pins_raw = {bus_master_n, mem_sixteen_select_n, zero_wait_request_n,
                     channel_ready, kbd_warm_reset_n, coproc_error_request};

  pin_sync #(
    .WIDTH (6),
    .INIT  (6'h3E)
  ) u_pin_sync (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .pin_in    (pins_raw),
    .level_out (pins_sync)
  );

  assign master_sync = ~pins_sync[5];
  assign cs16_sync_n = pins_sync[4];
  assign zws_sync_n  = pins_sync[3];
  assign rdy_sync    = pins_sync[2];
  assign kbd_sync_n  = pins_sync[1];
  assign cop_sync    = pins_sync[0];

  osc_divider u_osc_divider (
    .ref_oscillator_in (ref_oscillator_in),
    .osc_rst           (sys_rst),
    .timer_clk_out     (timer_clk_out) // RULE8
  );

  // Backplane clock toggles every ref_clk; commands launch on its rising phase
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bclk_ff <= 1'b0;
    end else begin
      bclk_ff <= ~bclk_ff; // RULE21
    end
  end
  assign backplane_clk = bclk_ff;

  // A card holding master low owns the bus
  assign master_active = master_sync; // RULE4

  // Cycle sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff   <= ST_IDLE;
      cmd_cnt_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // Start only on the clock phase so strobes align with the clock
          if (cyc_start && !master_active && bclk_ff) begin // RULE21
            state_ff <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          state_ff   <= ST_CMD;
          cmd_cnt_ff <= '0;
        end
        ST_CMD: begin
          cmd_cnt_ff <= cmd_cnt_ff + 4'h1;
          if (!zws_sync_n) begin
            state_ff <= ST_END; // RULE16
          end else if (cmd_cnt_ff >= CMD_MIN_CYCLES - 4'h1) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Stretch while ready is low; zero-wait ends at once
          if (!zws_sync_n || rdy_sync) begin // RULE22
            state_ff <= ST_END;
          end
        end
        ST_END: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Capture of the requested cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      kind_ff  <= CYC_CPU;
      write_ff <= 1'b0;
      io_ff    <= 1'b0;
      addr_ff  <= '0;
      be_ff    <= '0;
    end else if (state_ff == ST_IDLE && cyc_start && !master_active) begin
      kind_ff  <= cyc_kind;
      write_ff <= cyc_write;
      io_ff    <= cyc_io;
      addr_ff  <= host_address;
      be_ff    <= host_byte_enables;
    end
  end

  // Width set once the slave answers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sized_ff <= 1'b0;
    end else if (state_ff == ST_ADDR) begin
      sized_ff <= 1'b0;
    end else if (state_ff == ST_CMD && !cs16_sync_n) begin
      sized_ff <= 1'b1; // RULE5
    end
  end
  assign cyc_sized_16 = sized_ff;

  logic in_cmd;
  logic mem_rd;
  logic mem_wr;
  assign in_cmd = (state_ff == ST_CMD) || (state_ff == ST_WAIT);
  assign mem_rd = in_cmd && !io_ff && !write_ff && (kind_ff != CYC_MASTER);
  assign mem_wr = in_cmd && !io_ff && write_ff && (kind_ff != CYC_MASTER);

  assign cyc_busy = (state_ff != ST_IDLE);
  assign cyc_done = (state_ff == ST_END);

  // Read data captured at the end of the cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      host_read_data <= '0;
    end else if (state_ff == ST_WAIT && (rdy_sync || !zws_sync_n) && !write_ff) begin
      host_read_data <= system_data_bus_in;
    end else if (state_ff == ST_CMD && !zws_sync_n && !write_ff) begin
      host_read_data <= system_data_bus_in;
    end
  end

  // Memory strobes; refresh reads use the read strobe too
  assign bp_mem_read_n_out  = ~(mem_rd && below(addr_ff, LIMIT_16M)); // RULE6
  assign bp_mem_write_n_out = ~(mem_wr && below(addr_ff, LIMIT_16M)); // RULE7
  assign bp_mem_read_n_oe   = ~master_active; // RULE23
  assign bp_mem_write_n_oe  = ~master_active; // RULE23
  // Low copies follow the shared strobe, master-driven ones included
  logic [31:0] strobe_addr;
  logic        low_window;
  logic        shared_rd_n;
  logic        shared_wr_n;
  assign strobe_addr = master_active ? {8'h00, upper_unlatched_address_in,
                                        latched_system_address_in[16:0]} : addr_ff;
  assign low_window  = below(strobe_addr, LIMIT_1M);
  assign shared_rd_n = master_active ? bp_mem_read_n_in : bp_mem_read_n_out;
  assign shared_wr_n = master_active ? bp_mem_write_n_in : bp_mem_write_n_out;
  assign low_mem_read_n  = shared_rd_n | ~low_window; // RULE13
  assign low_mem_write_n = shared_wr_n | ~low_window; // RULE14

  // Address outputs
  assign upper_unlatched_address_out = addr_ff[23:17];
  assign upper_unlatched_address_oe  = ~master_active; // RULE2
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      latched_system_address_out <= '0;
    end else if (state_ff == ST_ADDR) begin
      if (kind_ff == CYC_REFRESH) begin
        latched_system_address_out <= {4'h0, refresh_address}; // RULE11
      end else begin
        latched_system_address_out <= {addr_ff[19:2], low_addr_bits(be_ff)}; // RULE10
      end
    end
  end
  assign latched_system_address_oe = ~master_active; // RULE11

  // High byte enable from the odd lanes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      latched_high_byte_enable_out <= 1'b0;
    end else if (state_ff == ST_ADDR) begin
      latched_high_byte_enable_out <= be_ff[1] | be_ff[3];
    end
  end
  assign latched_high_byte_enable_oe = cyc_busy && !master_active
                                       && (kind_ff == CYC_CPU || kind_ff == CYC_DMA); // RULE3

  // Data direction: drive on own writes, receive on reads and master cycles
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      system_data_bus_out <= '0;
    end else if (state_ff == ST_ADDR) begin
      system_data_bus_out <= host_write_data;
    end
  end
  assign system_data_bus_oe = in_cmd && write_ff && !master_active
                              && (kind_ff == CYC_CPU || kind_ff == CYC_DMA); // RULE12

  // Terminal count and speaker
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dma_terminal_count <= 1'b0;
      speaker_out        <= 1'b0;
    end else begin
      dma_terminal_count <= dma_count_end; // RULE15
      speaker_out        <= timer2_out & portb_spk_enable; // RULE19
    end
  end

  // Interrupt and warm reset requests are plain levels
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      coproc_irq_pending <= 1'b0;
      warm_reset_request <= 1'b0;
    end else begin
      coproc_irq_pending <= cop_sync; // RULE1
      warm_reset_request <= ~kbd_sync_n; // RULE17
    end
  end
  assign coproc_irq_number = COPROC_IRQ_NUM; // RULE1

  // Backplane reset spans reset plus a tail
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rst_cnt_ff          <= '0;
      backplane_reset_out <= 1'b1;
    end else if (rst_cnt_ff != RESET_HOLD) begin
      rst_cnt_ff          <= rst_cnt_ff + 4'h1;
      backplane_reset_out <= 1'b1; // RULE9
    end else begin
      backplane_reset_out <= 1'b0;
    end
  end

  // Strap taken first clock after reset; pin is input until then
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      strap_taken_ff <= 1'b0;
      cpu_mode_386   <= 1'b1;
    end else if (!strap_taken_ff) begin
      strap_taken_ff <= 1'b1;
      cpu_mode_386   <= clock_select_cpu_strap_in; // RULE18
    end
  end
  assign clock_select_cpu_strap_oe  = strap_taken_ff; // RULE18
  assign clock_select_cpu_strap_out = ~rtc_select;

  // ROM enable during a firmware read command
  assign fw_rom_output_enable = rom_access && in_cmd && !write_ff; // RULE20
endmodule
`default_nettype wire

// ---- isa_bp_checker.sv ----
// Backplane port assertions
`timescale 1ns/1ps
`default_nettype none
module isa_bp_checker
  import isa_bp_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // Cycle request and completion
  input wire logic        cyc_write,
  input wire logic [31:0] host_address,
  input wire logic        cyc_done,
  input wire logic        backplane_clk,
  // Strobes and directions
  input wire logic        bp_mem_read_n_out,
  input wire logic        bp_mem_write_n_out,
  input wire logic        low_mem_read_n,
  input wire logic        low_mem_write_n,
  input wire logic        master_active,
  input wire logic        upper_unlatched_address_oe,
  input wire logic        latched_system_address_oe,
  input wire logic        bp_mem_read_n_oe,
  input wire logic        bp_mem_write_n_oe,
  // Slave responses
  input wire logic        channel_ready,
  input wire logic        zero_wait_request_n,
  // Status, interrupt and resets
  input wire logic        coproc_error_request,
  input wire logic        coproc_irq_pending,
  input wire logic [3:0]  coproc_irq_number,
  input wire logic        kbd_warm_reset_n,
  input wire logic        warm_reset_request,
  input wire logic        backplane_reset_out,
  input wire logic        dma_count_end,
  input wire logic        dma_terminal_count
);
  logic rst_q_ff;

  // Delayed reset masks $past looking back into reset
  always_ff @(posedge ref_clk) begin
    rst_q_ff <= sys_rst;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || rst_q_ff);

  a_read_below_16m: assert property (!bp_mem_read_n_out |-> !cyc_write && host_address < LIMIT_16M)
    else $error("stray read strobe");
  a_write_below_16m: assert property (!bp_mem_write_n_out |-> cyc_write && host_address < LIMIT_16M)
    else $error("stray write strobe");
  a_low_read_1m: assert property (!low_mem_read_n |-> !bp_mem_read_n_out && host_address < LIMIT_1M)
    else $error("stray low read strobe");
  a_low_write_1m: assert property (!low_mem_write_n |-> !bp_mem_write_n_out && host_address < LIMIT_1M)
    else $error("stray low write strobe");
  a_master_release: assert property (master_active && $past(master_active) |-> !(upper_unlatched_address_oe || latched_system_address_oe || bp_mem_read_n_oe || bp_mem_write_n_oe))
    else $error("driven under master");
  a_bclk_toggle: assert property (backplane_clk != $past(backplane_clk))
    else $error("clock not toggling");
  a_ready_stretch: assert property ((!channel_ready && zero_wait_request_n) [*7] |-> !cyc_done)
    else $error("ended while not ready");
  a_coproc_irq: assert property (coproc_error_request [*7] |-> coproc_irq_pending && coproc_irq_number == COPROC_IRQ_NUM)
    else $error("coprocessor irq missing");
  a_warm_reset: assert property (!kbd_warm_reset_n [*7] |-> warm_reset_request)
    else $error("warm reset missing");
  a_reset_drive: assert property (disable iff (1'b0) sys_rst |=> backplane_reset_out)
    else $error("reset drive low");
  a_tc_follow: assert property ($rose(dma_count_end) |-> ##[1:2] dma_terminal_count)
    else $error("terminal count late");
endmodule
`default_nettype wire

// ---- isa_slave_model.sv ----
// Backplane memory card model
`timescale 1ns/1ps
`default_nettype none
module isa_slave_model (
  // Clock and backplane lines
  input  wire logic        ref_clk,
  input  wire logic        mem_rd_n,
  input  wire logic        mem_wr_n,
  input  wire logic [15:0] sd_wire,
  // Behaviour chosen by the bench
  input  wire logic        take_16,
  input  wire logic        fast,
  input  wire logic [7:0]  wait_cyc,
  input  wire logic [15:0] rd_word,
  // Responses
  output logic             mem16_n,
  output logic             zws_n,
  output logic             ready,
  output logic [15:0]      sd_drv,
  output logic [15:0]      wr_word
);
  logic [7:0]  cnt_ff;
  logic [15:0] last_ff;
  logic        cmd;

  assign cmd = !mem_rd_n || !mem_wr_n;
  // Card answers for every address
  assign mem16_n = !take_16;
  assign zws_n = !(cmd && fast);
  assign ready = !cmd || cnt_ff >= wait_cyc;
  // Released data lines keep changing so a stale value never matches
  assign sd_drv = mem_rd_n ? ~last_ff : rd_word;

  always @(posedge ref_clk) begin
    cnt_ff <= cmd ? cnt_ff + 8'h01 : 8'h00;
    last_ff <= sd_drv;
    if (!mem_wr_n) wr_word <= sd_wire;
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Bench for the backplane block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import isa_bp_pkg::*;
  logic ref_clk, sys_rst, ref_oscillator_in, cyc_start, cyc_write, cyc_io, rom_access;
  cycle_kind_t cyc_kind;
  logic [31:0] host_address;
  logic [3:0] host_byte_enables, coproc_irq_number;
  logic [15:0] refresh_address, host_write_data, host_read_data, sd_drv, rd_word, wr_word;
  logic [15:0] system_data_bus_in, system_data_bus_out;
  logic dma_count_end, timer2_out, portb_spk_enable, coproc_error_request, kbd_warm_reset_n;
  logic clock_select_cpu_strap_in, rtc_select, bus_master_n, mem_sixteen_select_n;
  logic zero_wait_request_n, channel_ready, latched_high_byte_enable_in;
  logic [6:0] upper_unlatched_address_in, upper_unlatched_address_out, la_cap;
  logic [19:0] latched_system_address_in, latched_system_address_out, sa_cap;
  logic bp_mem_read_n_in, bp_mem_write_n_in, cyc_busy, cyc_done, cyc_sized_16;
  logic timer_clk_out, dma_terminal_count, speaker_out, coproc_irq_pending;
  logic warm_reset_request, backplane_reset_out, clock_select_cpu_strap_out;
  logic clock_select_cpu_strap_oe, cpu_mode_386, fw_rom_output_enable, backplane_clk;
  logic master_active, upper_unlatched_address_oe, latched_system_address_oe;
  logic latched_high_byte_enable_out, latched_high_byte_enable_oe, system_data_bus_oe;
  logic bp_mem_read_n_out, bp_mem_read_n_oe, bp_mem_write_n_out, bp_mem_write_n_oe;
  logic low_mem_read_n, low_mem_write_n, strap, take_16, fast, hb_cap;
  logic lr_seen, lw_seen, mw_seen, rom_seen;
  logic [7:0] wait_cyc;
  int n_fail, cmp_count, cycles, osc_n, osc_at, osc_per, n_norm, n_fast, n_slow;

  // Idle levels of released lines
  assign bp_mem_read_n_in = bp_mem_read_n_oe ? bp_mem_read_n_out : 1'b1;
  assign bp_mem_write_n_in = bp_mem_write_n_oe ? bp_mem_write_n_out : 1'b1;
  assign upper_unlatched_address_in = upper_unlatched_address_oe ? upper_unlatched_address_out : 7'h2A;
  assign latched_system_address_in = latched_system_address_oe ? latched_system_address_out : 20'h5A5A5;
  assign latched_high_byte_enable_in = latched_high_byte_enable_oe ? latched_high_byte_enable_out : 1'b1;
  assign system_data_bus_in = system_data_bus_oe ? system_data_bus_out : sd_drv;
  assign clock_select_cpu_strap_in = clock_select_cpu_strap_oe ? clock_select_cpu_strap_out : strap;

  isa_backplane_interface uut (.*);
  isa_slave_model card (.ref_clk(ref_clk), .mem_rd_n(bp_mem_read_n_in),
    .mem_wr_n(bp_mem_write_n_in), .sd_wire(system_data_bus_in), .take_16(take_16),
    .fast(fast), .wait_cyc(wait_cyc), .rd_word(rd_word), .mem16_n(mem_sixteen_select_n),
    .zws_n(zero_wait_request_n), .ready(channel_ready), .sd_drv(sd_drv), .wr_word(wr_word));

  always #50 ref_clk = ~ref_clk;
  always #34.92 ref_oscillator_in = ~ref_oscillator_in;
  always @(posedge ref_oscillator_in) osc_n++;
  always @(posedge timer_clk_out) begin
    osc_per = osc_n - osc_at;
    osc_at = osc_n;
  end

  always @(posedge ref_clk) begin
    if (!low_mem_read_n) lr_seen <= 1'b1;
    if (!low_mem_write_n) lw_seen <= 1'b1;
    if (!bp_mem_write_n_out) mw_seen <= 1'b1;
    if (fw_rom_output_enable) rom_seen <= 1'b1;
    if (!bp_mem_read_n_out || !bp_mem_write_n_out) begin
      la_cap <= upper_unlatched_address_out;
      hb_cap <= latched_high_byte_enable_out;
    end
    if (cyc_busy) sa_cap <= latched_system_address_out;
  end

  // Run ceiling
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic do_reset(input logic s);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    strap <= s;
    wait_clk(16);
    chk(backplane_reset_out, 1);
    sys_rst <= 1'b0;
    rtc_select <= 1'b1;
    wait_clk(10);
    chk(backplane_reset_out, 1);
    wait_clk(10);
    chk(backplane_reset_out, 0);
    chk(cpu_mode_386, s);
    chk({clock_select_cpu_strap_oe, clock_select_cpu_strap_out}, 2'b10);
  endtask

  task automatic run_cyc(input cycle_kind_t k, input logic w, input logic [31:0] a,
                         input logic [3:0] be, input logic r, output int n);
    @(posedge ref_clk);
    {lr_seen, lw_seen, mw_seen, rom_seen} <= 4'h0;
    cyc_kind <= k;
    cyc_write <= w;
    host_address <= a;
    host_byte_enables <= be;
    rom_access <= r;
    cyc_start <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      if (cyc_busy === 1'b1) cyc_start <= 1'b0;
      n++;
      #1;
    end while (cyc_done !== 1'b1 && n < 300);
    chk(n < 300, 1);
  endtask

  task automatic t_read;
    take_16 <= 1'b1;
    run_cyc(CYC_CPU, 1'b0, 32'h000C_1234, 4'hC, 1'b1, n_norm);
    chk(host_read_data, 16'hA55A);
    chk(cyc_sized_16, 1);
    chk({lr_seen, rom_seen, hb_cap}, 3'b111);
    chk(sa_cap[1:0], 2'h2);
    chk(la_cap, 7'h06);
  endtask

  task automatic t_write;
    int n;
    take_16 <= 1'b0;
    wait_clk(4);
    host_write_data <= 16'h3C96;
    run_cyc(CYC_CPU, 1'b1, 32'h0050_0003, 4'h1, 1'b0, n);
    chk(wr_word, 16'h3C96);
    chk(cyc_sized_16, 0);
    chk({mw_seen, lw_seen, rom_seen, hb_cap}, 4'h8);
    chk({sa_cap[1:0], la_cap}, {2'h0, 7'h28});
  endtask

  task automatic t_waits;
    wait_cyc <= 8'h14;
    run_cyc(CYC_CPU, 1'b0, 32'h0000_8000, 4'hF, 1'b0, n_slow);
    chk(n_slow > n_norm + 10, 1);
    fast <= 1'b1;
    run_cyc(CYC_CPU, 1'b0, 32'h0000_8000, 4'hF, 1'b0, n_fast);
    chk(n_fast < n_slow - 10, 1);
    {fast, wait_cyc} <= 9'h000;
  endtask

  task automatic t_refresh;
    int n;
    refresh_address <= 16'hBEEF;
    run_cyc(CYC_REFRESH, 1'b0, 32'h0000_0000, 4'h1, 1'b0, n);
    chk(sa_cap[15:0], 16'hBEEF);
  endtask

  task automatic t_master;
    @(posedge ref_clk);
    bus_master_n <= 1'b0;
    wait_clk(8);
    chk(master_active, 1);
    chk({upper_unlatched_address_oe, latched_system_address_oe}, 0);
    chk({latched_high_byte_enable_oe, bp_mem_read_n_oe, bp_mem_write_n_oe}, 0);
    cyc_start <= 1'b1;
    wait_clk(6);
    chk(cyc_busy, 0);
    cyc_start <= 1'b0;
    bus_master_n <= 1'b1;
    wait_clk(8);
    chk({master_active, upper_unlatched_address_oe, latched_system_address_oe}, 3'b011);
  endtask

  task automatic t_misc;
    @(posedge ref_clk);
    coproc_error_request <= 1'b1;
    kbd_warm_reset_n <= 1'b0;
    dma_count_end <= 1'b1;
    wait_clk(8);
    chk({coproc_irq_pending, coproc_irq_number}, 5'h1D);
    chk({warm_reset_request, dma_terminal_count}, 2'b11);
    coproc_error_request <= 1'b0;
    kbd_warm_reset_n <= 1'b1;
    dma_count_end <= 1'b0;
    wait_clk(8);
    chk({coproc_irq_pending, warm_reset_request, dma_terminal_count}, 0);
    for (int i = 0; i < 4; i++) begin
      {timer2_out, portb_spk_enable} <= i[1:0];
      wait_clk(3);
      chk(speaker_out, i == 3);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    {ref_clk, ref_oscillator_in, cyc_start, cyc_write, cyc_io, rom_access} = 6'h00;
    {dma_count_end, timer2_out, portb_spk_enable, coproc_error_request} = 4'h0;
    {sys_rst, kbd_warm_reset_n, bus_master_n, strap, rtc_select} = 5'h1F;
    {take_16, fast, wait_cyc, rd_word} = {2'b00, 8'h00, 16'hA55A};
    {cyc_kind, host_address, host_byte_enables} = {CYC_CPU, 32'h0, 4'h0};
    {refresh_address, host_write_data} = 32'h0;
    do_reset(1'b1);
    t_read;
    t_write;
    t_waits;
    t_refresh;
    t_master;
    t_misc;
    do_reset(1'b0);
    chk(osc_per, OSC_DIV);
    final_report;
  end
endmodule

bind isa_backplane_interface isa_bp_checker chk_i (.*);
`default_nettype wire
